// ==== design/odt_pkg.sv ====
// =====================================================================
// shared constants for the termination controller
package odt_pkg;

    // =================================================================
    // register byte offsets on the register bus
    localparam logic [7:0] ADDR_NOM_CFG  = 8'h00;  // nominal strength, additive latency
    localparam logic [7:0] ADDR_WR_CFG   = 8'h04;  // write strength, cas write latency
    localparam logic [7:0] ADDR_PD_CFG   = 8'h08;  // power-down dll keep, burst mode
    localparam logic [7:0] ADDR_STATUS   = 8'h0c;  // read-only live state

    // =================================================================
    // field positions
    localparam int NOM_CODE_LSB   = 0;   // 3 bits: nominal code {a9,a6,a2}
    localparam int NOM_AL_LSB     = 3;   // 5 bits: additive latency
    localparam int WR_CODE_LSB    = 0;   // 2 bits: write code {a10,a9}
    localparam int WR_CWL_LSB     = 2;   // 5 bits: cas write latency
    localparam int PD_KEEP_BIT    = 0;   // dll kept on in precharge power-down
    localparam int PD_BURST_LSB   = 1;   // 2 bits: burst mode
    localparam int ST_EN_BIT      = 0;
    localparam int ST_WR_BIT      = 1;
    localparam int ST_SYNC_BIT    = 2;
    localparam int ST_DYN_BIT     = 3;
    localparam int ST_PIN_BIT     = 4;
    localparam int ST_LAT_LSB     = 8;   // 5 bits: active latency

    // =================================================================
    // values after reset
    localparam logic [2:0] RST_NOM_CODE = 3'h0;
    localparam logic [4:0] RST_AL       = 5'h00;
    localparam logic [1:0] RST_WR_CODE  = 2'h0;
    localparam logic [4:0] RST_CWL      = 5'h05;
    localparam logic       RST_PD_KEEP  = 1'b0;
    localparam logic [1:0] RST_BURST    = 2'h0;

    // =================================================================
    // burst mode codes
    localparam logic [1:0] BURST_BL8 = 2'h0;  // fixed burst of eight
    localparam logic [1:0] BURST_OTF = 2'h1;  // chosen per write command
    localparam logic [1:0] BURST_BC4 = 2'h2;  // fixed burst chop four

    // =================================================================
    // latency figures, in link clock cycles
    localparam logic [5:0] LAT_TRIM        = 6'h02;  // latencies are write latency less two
    localparam logic [3:0] REVERT_CHOP     = 4'h4;   // extra cycles after chop-four write
    localparam logic [3:0] REVERT_FULL     = 4'h6;   // extra cycles after burst-eight write
    localparam int         HIST_DEPTH      = 32;     // history kept per sampled pin

endpackage

// ==== design/odt_cfg_if.sv ====
`timescale 1ns/1ns
// =====================================================================
// configuration out of and status into the register file
interface odt_cfg_if;
    logic [2:0] nom_code;
    logic [4:0] al;
    logic [1:0] wr_code;
    logic [4:0] cwl;
    logic       pd_keep;
    logic [1:0] burst;
    logic       st_en;
    logic       st_wr;
    logic       st_sync;
    logic       st_dyn;
    logic       st_pin;
    logic [4:0] st_lat;

    modport regs (
        output nom_code, al, wr_code, cwl, pd_keep, burst,
        input  st_en, st_wr, st_sync, st_dyn, st_pin, st_lat
    );
    modport core (
        input  nom_code, al, wr_code, cwl, pd_keep, burst,
        output st_en, st_wr, st_sync, st_dyn, st_pin, st_lat
    );
endinterface

// ==== design/odt_regs.sv ====
`timescale 1ns/1ns
// =====================================================================
// ahb-lite slave holding the mode bits; zero wait states, always okay
module odt_regs (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // configuration and status
    odt_cfg_if.regs          cfg
);

    logic        wr_pend_q;
    logic [7:0]  wr_addr_q;
    logic [31:0] rdata_q;
    logic [2:0]  nom_code_q;
    logic [4:0]  al_q;
    logic [1:0]  wr_code_q;
    logic [4:0]  cwl_q;
    logic        pd_keep_q;
    logic [1:0]  burst_q;
    logic        take;

    // read mux; unmapped offsets read as zero
    function automatic logic [31:0] read_word(input logic [7:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (a == odt_pkg::ADDR_NOM_CFG) begin
            w[odt_pkg::NOM_CODE_LSB +: 3] = nom_code_q;
            w[odt_pkg::NOM_AL_LSB +: 5]   = al_q;
        end else if (a == odt_pkg::ADDR_WR_CFG) begin
            w[odt_pkg::WR_CODE_LSB +: 2] = wr_code_q;
            w[odt_pkg::WR_CWL_LSB +: 5]  = cwl_q;
        end else if (a == odt_pkg::ADDR_PD_CFG) begin
            w[odt_pkg::PD_KEEP_BIT]       = pd_keep_q;
            w[odt_pkg::PD_BURST_LSB +: 2] = burst_q;
        end else if (a == odt_pkg::ADDR_STATUS) begin
            w[odt_pkg::ST_EN_BIT]       = cfg.st_en;
            w[odt_pkg::ST_WR_BIT]       = cfg.st_wr;
            w[odt_pkg::ST_SYNC_BIT]     = cfg.st_sync;
            w[odt_pkg::ST_DYN_BIT]      = cfg.st_dyn;
            w[odt_pkg::ST_PIN_BIT]      = cfg.st_pin;
            w[odt_pkg::ST_LAT_LSB +: 5] = cfg.st_lat;
        end
        return w;
    endfunction

    assign take      = hsel & htrans[1] & hready;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;

    // address phase: remember writes, fetch read data for the data phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            rdata_q   <= 32'h0000_0000;
        end else begin
            wr_pend_q <= take & hwrite & (hsize == 3'h2);  // whole words only
            wr_addr_q <= haddr[7:0];
            if (take & ~hwrite) begin
                rdata_q <= read_word(haddr[7:0]);
            end
        end
    end

    // data phase: store write data; status offset ignores writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nom_code_q <= odt_pkg::RST_NOM_CODE;
            al_q       <= odt_pkg::RST_AL;
            wr_code_q  <= odt_pkg::RST_WR_CODE;
            cwl_q      <= odt_pkg::RST_CWL;
            pd_keep_q  <= odt_pkg::RST_PD_KEEP;
            burst_q    <= odt_pkg::RST_BURST;
        end else if (wr_pend_q) begin
            if (wr_addr_q == odt_pkg::ADDR_NOM_CFG) begin
                nom_code_q <= hwdata[odt_pkg::NOM_CODE_LSB +: 3];
                al_q       <= hwdata[odt_pkg::NOM_AL_LSB +: 5];
            end else if (wr_addr_q == odt_pkg::ADDR_WR_CFG) begin
                wr_code_q <= hwdata[odt_pkg::WR_CODE_LSB +: 2];
                cwl_q     <= hwdata[odt_pkg::WR_CWL_LSB +: 5];
            end else if (wr_addr_q == odt_pkg::ADDR_PD_CFG) begin
                pd_keep_q <= hwdata[odt_pkg::PD_KEEP_BIT];
                burst_q   <= hwdata[odt_pkg::PD_BURST_LSB +: 2];
            end
        end
    end

    assign cfg.nom_code = nom_code_q;
    assign cfg.al       = al_q;
    assign cfg.wr_code  = wr_code_q;
    assign cfg.cwl      = cwl_q;
    assign cfg.pd_keep  = pd_keep_q;
    assign cfg.burst    = burst_q;

endmodule

// ==== design/odt_ctrl_top.sv ====
// The address map and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
// =====================================================================
module odt_ctrl_top (
    // system clock and reset
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_SYS_RST,

    // ahb-lite register port
    input  wire logic        I_HSEL,
    input  wire logic [31:0] I_HADDR,
    input  wire logic [1:0]  I_HTRANS,
    input  wire logic        I_HWRITE,
    input  wire logic [2:0]  I_HSIZE,
    input  wire logic [31:0] I_HWDATA,
    input  wire logic        I_HREADY,
    output logic             O_HREADYOUT,
    output logic             O_HRESP,
    output logic [31:0]      O_HRDATA,

    // dram pins, asynchronous to the system clock
    input  wire logic        I_DDR_CK,
    input  wire logic        I_ODT,
    input  wire logic        I_WR_CMD,
    input  wire logic        I_BC4_OTF,

    // device state from the rest of the dram core
    input  wire logic        I_DLL_LOCKED,
    input  wire logic        I_PRECHARGE_PD,
    input  wire logic        I_SELF_REFRESH,
    input  wire logic        I_READ_DRIVE,

    // termination control
    output logic             O_RTT_EN,
    output logic             O_RTT_WR_SEL,
    output logic [2:0]       O_RTT_CODE
);

    // =================================================================
    // register file
    odt_cfg_if cfg_bus ();

    odt_regs u_regs (
        .clk       (I_SYS_CLK),
        .rst       (I_SYS_RST),
        .hsel      (I_HSEL),
        .haddr     (I_HADDR),
        .htrans    (I_HTRANS),
        .hwrite    (I_HWRITE),
        .hsize     (I_HSIZE),
        .hwdata    (I_HWDATA),
        .hready    (I_HREADY),
        .hreadyout (O_HREADYOUT),
        .hresp     (O_HRESP),
        .hrdata    (O_HRDATA),
        .cfg       (cfg_bus.regs)
    );

    // =================================================================
    // pin synchronisers
    logic [3:0] pin_s1_q;
    logic [3:0] pin_s2_q;

    // edge finder, pin copies
    logic       ck_prev_q;
    logic       ck_rise;
    logic       ck_fall;
    logic       ck_s;
    logic       odt_s;
    logic       wr_s;
    logic       bc4_s;

    // two stages for every pin; only the second stage is looked at
    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            pin_s1_q <= 4'h0;
            pin_s2_q <= 4'h0;
        end else begin
            pin_s1_q <= {I_BC4_OTF, I_WR_CMD, I_ODT, I_DDR_CK};
            pin_s2_q <= pin_s1_q;
        end
    end

    // settled pins
    assign ck_s  = pin_s2_q[0];
    assign odt_s = pin_s2_q[1];
    assign wr_s  = pin_s2_q[2];
    assign bc4_s = pin_s2_q[3];

    // link clock edge finder; all pins share the same delay, so sampling
    // them at the detected rise keeps their setup relation to the clock
    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            ck_prev_q <= 1'b0;
        end else begin
            ck_prev_q <= ck_s;
        end
    end

    // link edge strobes
    assign ck_rise = ck_s & ~ck_prev_q;
    assign ck_fall = ~ck_s & ck_prev_q;

    // =================================================================
    // mode decode
    logic [5:0] wl;
    logic [4:0] lat;

    // mode flags
    logic       sync_mode;
    logic       dyn_en;
    logic       honour;

    // write latency less two, clamped so a tiny setting never underflows
    assign wl  = {1'b0, cfg_bus.cwl} + {1'b0, cfg_bus.al};
    assign lat = (wl > odt_pkg::LAT_TRIM) ? 5'(wl - odt_pkg::LAT_TRIM) : 5'h00;

    // async-mode behaviour in frozen power-down is not modelled: outside
    // synchronous mode the termination is simply held off
    assign sync_mode = I_DLL_LOCKED & ~(I_PRECHARGE_PD & ~cfg_bus.pd_keep);
    assign dyn_en    = |cfg_bus.wr_code;

    // ignored in self refresh or with all codes zero
    assign honour    = ((|cfg_bus.nom_code) | dyn_en) & ~I_SELF_REFRESH & sync_mode;

    // =================================================================
    // per-cycle history of pin and write samples
    logic [odt_pkg::HIST_DEPTH-1:0] odt_hist_q;
    logic [odt_pkg::HIST_DEPTH-1:0] wr_hist_q;
    logic [odt_pkg::HIST_DEPTH-1:0] bc4_hist_q;

    logic [odt_pkg::HIST_DEPTH-1:0] odt_hist_d;
    logic [odt_pkg::HIST_DEPTH-1:0] wr_hist_d;
    logic [odt_pkg::HIST_DEPTH-1:0] bc4_hist_d;

    // pick the sample taken a given number of link edges ago
    function automatic logic tap(input logic [odt_pkg::HIST_DEPTH-1:0] h, input logic [4:0] n);
        return h[n];
    endfunction

    // shift in the newest sample
    assign odt_hist_d = {odt_hist_q[odt_pkg::HIST_DEPTH-2:0], odt_s};
    assign wr_hist_d  = {wr_hist_q[odt_pkg::HIST_DEPTH-2:0], wr_s};
    assign bc4_hist_d = {bc4_hist_q[odt_pkg::HIST_DEPTH-2:0], bc4_s};

    // a shift line rather than one counter, so pulses and writes closer
    // together than the latency are each delayed on their own,
    // at the cost of a 32-deep line per pin
    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            odt_hist_q <= '0;
            wr_hist_q  <= '0;
            bc4_hist_q <= '0;
        end else if (ck_rise) begin
            odt_hist_q <= odt_hist_d;
            wr_hist_q  <= wr_hist_d;
            bc4_hist_q <= bc4_hist_d;
        end
    end

    // =================================================================
    // on/off target at each link rise
    logic odt_tgt_q;
    logic odt_due;

    // pin value that has now served out its latency
    assign odt_due = tap(odt_hist_d, lat);

    // target for the next fall
    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            odt_tgt_q <= 1'b0;
        end else if (ck_rise) begin
            odt_tgt_q <= odt_due;
        end
    end

    // =================================================================
    // write strength window
    logic [3:0] revert_cnt_q;

    logic       wr_due;
    logic       wr_chop;
    logic       wr_active;

    // write past its latency
    assign wr_due = tap(wr_hist_d, lat);

    // burst length of the write that just reached its switch point
    always_comb begin
        case (cfg_bus.burst)
            odt_pkg::BURST_BC4: wr_chop = 1'b1;
            odt_pkg::BURST_OTF: wr_chop = tap(bc4_hist_d, lat);
            default:            wr_chop = 1'b0;
        endcase
    end

    // count link edges from the switch point to the return to nominal;
    // a newer write reloads, so nominal returns after the last one only
    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            revert_cnt_q <= 4'h0;
        end else if (~dyn_en) begin
            revert_cnt_q <= 4'h0;
        end else if (ck_rise) begin
            if (wr_due) begin
                revert_cnt_q <= wr_chop ? odt_pkg::REVERT_CHOP : odt_pkg::REVERT_FULL;
            end else if (revert_cnt_q != 4'h0) begin
                revert_cnt_q <= revert_cnt_q - 4'h1;
            end
        end
    end

    // while the count runs
    assign wr_active = revert_cnt_q != 4'h0;

    // =================================================================
    // termination outputs
    logic       rtt_on_q;
    logic       rtt_wr_q;
    logic [2:0] rtt_code_q;

    logic [2:0] code_sel;

    // turn-on acts at the rise, turn-off half a link clock later at the
    // fall; the change completes in one system cycle, well inside the
    // window.  gating by mode and read drive acts at once
    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            rtt_on_q <= 1'b0;
        end else if (~honour | I_READ_DRIVE) begin
            rtt_on_q <= 1'b0;
        end else if (ck_rise & odt_due) begin
            rtt_on_q <= 1'b1;
        end else if (ck_fall & ~odt_tgt_q) begin
            rtt_on_q <= 1'b0;
        end else if (odt_tgt_q & ~rtt_on_q) begin
            rtt_on_q <= 1'b1;  // drive released after a read
        end
    end

    // strength change lands on the fall after the switch point
    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            rtt_wr_q <= 1'b0;
        end else if (~dyn_en) begin
            rtt_wr_q <= 1'b0;
        end else if (ck_fall) begin
            rtt_wr_q <= wr_active;
        end
    end

    // write code is zero-extended to the width of the nominal code
    assign code_sel = rtt_wr_q ? {1'b0, cfg_bus.wr_code} : cfg_bus.nom_code;

    // code from a flip-flop
    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            rtt_code_q <= 3'h0;
        end else begin
            rtt_code_q <= code_sel;
        end
    end

    // pins from flip-flops
    assign O_RTT_EN     = rtt_on_q;
    assign O_RTT_WR_SEL = rtt_wr_q;
    assign O_RTT_CODE   = rtt_code_q;

    // =================================================================
    // status back to software
    assign cfg_bus.st_en   = rtt_on_q;
    assign cfg_bus.st_wr   = rtt_wr_q;

    // mode as decoded, and the settled odt pin
    assign cfg_bus.st_sync = sync_mode;
    assign cfg_bus.st_dyn  = dyn_en;
    assign cfg_bus.st_pin  = odt_s;
    assign cfg_bus.st_lat  = lat;

endmodule

// ==== testbench/odt_ctrl_assertions.sv ====
`timescale 1ns/1ns
// =====================================================================
// port checker; everything lives in the system clock domain
module odt_chk (
    // clock and reset
    input  wire logic       I_SYS_CLK,
    input  wire logic       I_SYS_RST,
    // observed pins
    input  wire logic       I_DDR_CK,
    input  wire logic       I_DLL_LOCKED,
    input  wire logic       I_PRECHARGE_PD,
    input  wire logic       I_SELF_REFRESH,
    input  wire logic       I_READ_DRIVE,
    input  wire logic       O_HREADYOUT,
    input  wire logic       O_HRESP,
    input  wire logic       O_RTT_EN,
    input  wire logic       O_RTT_WR_SEL,
    input  wire logic [2:0] O_RTT_CODE
);
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (I_SYS_RST);

    // no forcing input active
    logic quiet;
    assign quiet = !I_SELF_REFRESH && I_DLL_LOCKED && !I_READ_DRIVE && !I_PRECHARGE_PD;

    // =================================================================
    // bus and forcing
    chk_ready_high: assert property (O_HREADYOUT) else $error("hready went low");
    chk_resp_okay: assert property (!O_HRESP) else $error("error response seen");
    chk_sr_off: assert property (I_SELF_REFRESH && $past(I_SELF_REFRESH) |-> !O_RTT_EN)
        else $error("termination on in self refresh");
    chk_dll_off: assert property (!I_DLL_LOCKED && !$past(I_DLL_LOCKED) |-> !O_RTT_EN)
        else $error("termination on with dll unlocked");
    chk_read_off: assert property (I_READ_DRIVE [*2] |-> !O_RTT_EN)
        else $error("termination on while driving");
    chk_wr_code: assert property (O_RTT_WR_SEL [*2] |-> !O_RTT_CODE[2])
        else $error("write code has top bit set");

    // =================================================================
    // link timing: changes follow a detected link clock edge
    chk_on_edge: assert property ($rose(O_RTT_EN) && $past(quiet) && $past(quiet, 2) && $past(quiet, 3)
        |-> $past(I_DDR_CK, 2)) else $error("turn-on away from a clock rise");
    chk_off_edge: assert property ($fell(O_RTT_EN) && $past(quiet) && $past(quiet, 2)
        |-> !$past(I_DDR_CK, 2)) else $error("turn-off away from a clock fall");
    chk_sel_rise: assert property ($rose(O_RTT_WR_SEL) |-> !$past(I_DDR_CK, 2))
        else $error("write strength away from a clock fall");
    chk_sel_fall: assert property ($fell(O_RTT_WR_SEL) |-> !$past(I_DDR_CK, 2))
        else $error("nominal return away from a clock fall");
endmodule

bind odt_ctrl_top odt_chk i_chk (.I_SYS_CLK, .I_SYS_RST, .I_DDR_CK, .I_DLL_LOCKED, .I_PRECHARGE_PD,
    .I_SELF_REFRESH, .I_READ_DRIVE, .O_HREADYOUT, .O_HRESP, .O_RTT_EN, .O_RTT_WR_SEL, .O_RTT_CODE);

// ==== testbench/odt_ctl_model.sv ====
`timescale 1ns/1ns
// =====================================================================
// memory controller side: link clock, termination pin, write commands
module odt_ctl_model (
    // link pins
    output logic o_ck,
    output logic o_odt,
    output logic o_wr,
    output logic o_bc4
);
    int rise_n = 0;  // link rises since time zero

    // free-running link clock, unrelated phase
    initial begin
        o_ck = 1'b0;
        o_odt = 1'b0;
        o_wr = 1'b0;
        o_bc4 = 1'b0;
        #3;
        forever #80 o_ck = ~o_ck;
    end

    // count rises so the bench can express latencies in link cycles
    always @(posedge o_ck) begin
        rise_n++;
    end

    // one pin pulse, no read issued in it writes at offsets wa, wb (<0: none)
    task automatic pulse(input int hi, input int wa, input int wb, input logic bc4,
                         output int r_hi, output int r_lo, output int r_wr);
        int hold;
        hold = bc4 ? 4 : 6;  // hold after a write
        @(negedge o_ck);
        o_odt = 1'b1;
        r_hi = rise_n + 1;
        r_wr = -1;
        // never shorter than four cycles
        for (int i = 0; i < hi || i < 4 || (r_wr >= 0 && i < r_wr - r_hi + hold); i++) begin
            if (i == wa || i == wb) begin
                o_wr = 1'b1;
                o_bc4 = bc4;
                r_wr = r_hi + i;
            end
            @(negedge o_ck);
            o_wr = 1'b0;
            o_bc4 = ~bc4;  // don't care outside a write
        end
        o_odt = 1'b0;
        r_lo = rise_n + 1;
    endtask
endmodule

// ==== testbench/tb_ddr3_odt_control.sv ====
`timescale 1ns/1ns
// =====================================================================
// self-checking bench for the termination controller
module tb_ddr3_odt_control;
    logic        clk, rst, hsel, hwrite, ck, odt, wr, bc4, dll, pd, sr, rd, hrdy, hresp, en, wsel;
    logic [1:0]  htrans;
    logic [2:0]  hsize, code;
    logic [31:0] haddr, hwdata, hrdata;
    int          fail_count = 0;
    int          num_checks = 0;
    int          on_ck, off_ck, ws_ck, wn_ck;

    // system clock, 100 MHz
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    odt_ctrl_top i_dut (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
        .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hrdy), .O_HREADYOUT(hrdy),
        .O_HRESP(hresp), .O_HRDATA(hrdata), .I_DDR_CK(ck), .I_ODT(odt), .I_WR_CMD(wr), .I_BC4_OTF(bc4),
        .I_DLL_LOCKED(dll), .I_PRECHARGE_PD(pd), .I_SELF_REFRESH(sr), .I_READ_DRIVE(rd), .O_RTT_EN(en),
        .O_RTT_WR_SEL(wsel), .O_RTT_CODE(code));
    odt_ctl_model i_ctl (.o_ck(ck), .o_odt(odt), .o_wr(wr), .o_bc4(bc4));

    // link rise index at which each output moved
    always @(posedge en) on_ck = i_ctl.rise_n;
    always @(negedge en) off_ck = i_ctl.rise_n;
    always @(posedge wsel) ws_ck = i_ctl.rise_n;
    always @(negedge wsel) wn_ck = i_ctl.rise_n;

    // =================================================================
    // reporting
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // =================================================================
    // ahb-lite master; a wait that never ends counts as a mismatch
    task automatic rdy();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hrdy !== 1'b1 && n < 20);
        if (hrdy !== 1'b1) begin
            fail_count++;
            test_done();
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [2:0] sz,
                       output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        hsize <= sz;
        rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        r = hrdata;
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, 3'h2, r);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, 3'h2, r);
        chk(r & m, e);
    endtask

    task automatic cfg(input logic [2:0] nom, input logic [4:0] al, input logic [1:0] wc,
                       input logic [4:0] cwl, input logic [1:0] bm);
        wreg(odt_pkg::ADDR_NOM_CFG, {24'h0, al, nom});
        wreg(odt_pkg::ADDR_WR_CFG, {25'h0, cwl, wc});
        wreg(odt_pkg::ADDR_PD_CFG, {29'h0, bm, 1'b0});
    endtask

    // wait until the link has reached a given rise, bounded
    task automatic settle(input int tgt);
        int n;
        n = 0;
        while (i_ctl.rise_n < tgt && n < 8000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 8000) begin
            fail_count++;
            test_done();
        end
        tick(8);
    endtask

    // one pin pulse, then compare every recorded change with its latency
    task automatic run(input int lat, input int hi, input int wa, input int wb, input logic b4,
                       input int rev, input logic on);
        int rh, rl, rw;
        on_ck = -1;
        off_ck = -1;
        ws_ck = -1;
        wn_ck = -1;
        i_ctl.pulse(hi, wa, wb, b4, rh, rl, rw);
        settle(rl + lat + 8);
        chk(on_ck, on ? rh + lat : -1);
        chk(off_ck, on ? rl + lat : -1);
        chk(ws_ck, rev > 0 ? rh + wa + lat : -1);
        chk(wn_ck, rev > 0 ? rw + lat + rev : -1);
    endtask

    // =================================================================
    // scenarios
    task automatic t_regs();
        logic [31:0] r;
        rchk(odt_pkg::ADDR_NOM_CFG, 32'hffffffff, 32'h0);
        rchk(odt_pkg::ADDR_WR_CFG, 32'hffffffff, 32'h14);
        rchk(8'h10, 32'hffffffff, 32'h0);
        wreg(odt_pkg::ADDR_STATUS, 32'hffffffff);
        cfg(3'h5, 5'h03, 2'h0, 5'h06, odt_pkg::BURST_BL8);
        bus(1'b1, odt_pkg::ADDR_NOM_CFG, 32'h3f, 3'h0, r);  // byte write must be ignored
        rchk(odt_pkg::ADDR_NOM_CFG, 32'hffffffff, 32'h1d);
        rchk(odt_pkg::ADDR_STATUS, 32'h1f00, 32'h0700);
        $display("test regs done");
    endtask

    task automatic t_lat();
        int cwl[3] = '{5, 6, 8};
        int al[3] = '{0, 3, 5};
        cfg(3'h0, 5'h00, 2'h0, 5'h05, odt_pkg::BURST_BL8);
        run(3, 5, -1, -1, 1'b0, 0, 1'b0);
        for (int i = 0; i < 3; i++) begin
            cfg(3'h5, al[i][4:0], 2'h0, cwl[i][4:0], odt_pkg::BURST_BL8);
            run(cwl[i] + al[i] - 2, 5, 2, -1, 1'b0, 0, 1'b1);
        end
        $display("test latency done");
    endtask

    task automatic t_dyn();
        logic [1:0] bm[4] = '{odt_pkg::BURST_BL8, odt_pkg::BURST_BC4, odt_pkg::BURST_OTF, odt_pkg::BURST_OTF};
        for (int i = 0; i < 4; i++) begin
            cfg(3'h5, 5'h01, 2'h2, 5'h05, bm[i]);
            run(4, 4, 1, -1, i == 1 || i == 2, (i == 1 || i == 2) ? 4 : 6, 1'b1);
        end
        cfg(3'h2, 5'h00, 2'h1, 5'h05, odt_pkg::BURST_BL8);
        run(3, 4, 0, 3, 1'b0, 6, 1'b1);
        $display("test dynamic done");
    endtask

    task automatic t_force();
        int rh, rl, rw;
        cfg(3'h5, 5'h00, 2'h0, 5'h05, odt_pkg::BURST_BL8);
        fork
            i_ctl.pulse(40, -1, -1, 1'b0, rh, rl, rw);
            begin
                settle(i_ctl.rise_n + 8);
                chk(en, 1'b1);
                chk(code, 3'h5);
                for (int k = 0; k < 4; k++) begin
                    {sr, dll, rd, pd} <= 4'b0100 ^ (4'b1000 >> k);
                    tick(3);
                    chk(en, 1'b0);
                    {sr, dll, rd, pd} <= 4'b0100;
                    tick(3);
                    chk(en, 1'b1);
                end
                wreg(odt_pkg::ADDR_PD_CFG, 32'h1);
                pd <= 1'b1;
                tick(3);
                chk(en, 1'b1);
                pd <= 1'b0;
            end
        join
        settle(rl + 11);
        $display("test forcing done");
    endtask

    // =================================================================
    // main sequence
    initial begin
        rst = 1'b1;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        {sr, dll, rd, pd} = 4'b0100;
        tick(6);
        rst <= 1'b0;
        tick(4);
        t_regs();
        t_lat();
        t_dyn();
        t_force();
        test_done();
    end
endmodule
